// file: gpcfg_defines.svh
/*
  Constants for the port pin configuration block: register addresses,
  subregister indices, reset values and bus widths.
  Assumes inclusion by bare name from the package.
*/
`ifndef GPCFG_DEFINES_SVH
`define GPCFG_DEFINES_SVH

`define GPCFG_ADDR_W          12
`define GPCFG_PORT_A_IN_ADDR  12'hFD2
`define GPCFG_PORT_B_IN_ADDR  12'hFD6
`define GPCFG_PORT_C_IN_ADDR  12'hFDA
`define GPCFG_PORT_A_ADR_ADDR 12'hFD0
`define GPCFG_PORT_A_CTL_ADDR 12'hFD1
`define GPCFG_PORT_STRIDE     12'h004
`define GPCFG_IDX_AF_ENABLE   8'h02
`define GPCFG_IDX_WAKE_EN     8'h05
`define GPCFG_IDX_PULLUP      8'h06
`define GPCFG_IDX_AFS_LOW     8'h07
`define GPCFG_IDX_AFS_HIGH    8'h08
`define GPCFG_CFG_RESET       8'h00
`define GPCFG_IDX_RESET       8'h00
`define GPCFG_NUM_PORTS       4

`endif

// file: gpcfg_pkg.sv
/*
  Types shared by the port pin configuration block.
  Assumes gpcfg_defines.svh is on the include path.
*/
package gpcfg_pkg;
  `include "gpcfg_defines.svh"

  typedef struct packed {
    logic [7:0] wake_en;
    logic [7:0] pullup_en;
    logic [7:0] afs_low;
    logic [7:0] afs_high;
  } gpcfg_port_cfg_t;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`GPCFG_ADDR_W-1:0]  addr;
    logic [7:0]                wdata;
  } gpcfg_bus_req_t;
endpackage

// file: gpcfg_port_pins.sv
/*
  Per-pin configuration for ports A to D: wake source, pull-up and
  alternate function select subregisters, reached through each port's
  address and control registers, plus input data registers for A to C.
  Assumes a synchronous byte register bus from the core, pins already
  synchronous to ref_clk, and a stop_mode level from the power manager.
*/
`timescale 1ns/10ps

module gpcfg_port_pins
  import gpcfg_pkg::*;
#(
  parameter logic [31:0] PIN_PRESENT  = 32'hFFFFFFFF, // Bonded pins, port D in top byte.
  parameter logic [63:0] AF_CODE_MAP  = 64'h0000000000000000 // Per-pin 2-bit code remap.
) (
  input  wire logic                   ref_clk,        // System clock, 10 MHz.
  input  wire logic                   resetn,         // Synchronous reset, active low.
  input  wire gpcfg_bus_req_t         bus_req,        // Register access request.
  output logic [7:0]                  bus_rdata,      // Read data, registered.
  input  wire logic [31:0]            pin_level,      // Pin input levels, ports A..D.
  input  wire logic [31:0]            pin_af_enable,  // Alternate function enable bits.
  input  wire logic [31:0]            pin_direction,  // Direction bits, 1 is input.
  input  wire logic                   stop_mode,      // Device is in stop mode.
  output logic                        stop_recover,   // One-cycle recovery request.
  output logic [31:0]                 pin_pullup_on,  // Weak pull-up per pin.
  output logic [31:0]                 pin_af_active,  // Pin owned by its function.
  output logic [63:0]                 pin_af_code,    // Selected function per pin.
  output logic [31:0]                 pin_normal_oe   // Normal-mode output enable.
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Maps an address onto a port: bit 2 flags a hit and bits 1:0 name the
  // port. Each port's registers sit four bytes above the previous port's,
  // so the low two bits of the distance from the base must be zero.
  function automatic logic [2:0] port_of(input logic [`GPCFG_ADDR_W-1:0] a,
                                         input logic [`GPCFG_ADDR_W-1:0] base);
    logic [`GPCFG_ADDR_W-1:0] d;
    d = a - base;
    if (a >= base && d[1:0] == 2'b00 && d[`GPCFG_ADDR_W-1:2] < `GPCFG_NUM_PORTS)
      port_of = {1'b1, d[3:2]};
    else
      port_of = 3'b000;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  gpcfg_port_cfg_t cfg_reg [`GPCFG_NUM_PORTS];
  gpcfg_port_cfg_t cfg_next [`GPCFG_NUM_PORTS];
  logic [7:0]      idx_reg [`GPCFG_NUM_PORTS];
  logic [7:0]      idx_next [`GPCFG_NUM_PORTS];
  logic [31:0]     sample_reg;
  logic [31:0]     sample_next;
  logic [31:0]     prev_reg;
  logic [31:0]     prev_next;
  logic            recover_reg;
  logic            recover_next;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic [2:0]      adr_hit;
  logic [2:0]      ctl_hit;
  logic [2:0]      in_hit;
  // Pin levels with unbonded pins forced low; both the input registers
  // and the wake detector read only this copy.
  logic [31:0]     visible;

  always_comb begin
    adr_hit = port_of(bus_req.addr, `GPCFG_PORT_A_ADR_ADDR);
    ctl_hit = port_of(bus_req.addr, `GPCFG_PORT_A_CTL_ADDR);
    in_hit  = port_of(bus_req.addr, `GPCFG_PORT_A_IN_ADDR);
    // A write that falls outside every map is ignored; such a read returns zero.
    visible = pin_level & PIN_PRESENT;
  end

  // ----------------------------------------------------------------
  // Index and configuration subregisters
  // ----------------------------------------------------------------
  // An index write lands at the edge that takes it, so a control access
  // in the very next cycle already reaches the new subregister. Unknown
  // indices leave every subregister as it is.
  always_comb begin
    for (int p = 0; p < `GPCFG_NUM_PORTS; p++) begin
      cfg_next[p] = cfg_reg[p];
      idx_next[p] = idx_reg[p];
    end
    if (bus_req.wr) begin
      if (adr_hit[2])
        idx_next[adr_hit[1:0]] = bus_req.wdata;
      if (ctl_hit[2]) begin
        unique case (idx_reg[ctl_hit[1:0]])
          `GPCFG_IDX_WAKE_EN:  cfg_next[ctl_hit[1:0]].wake_en  = bus_req.wdata;
          `GPCFG_IDX_PULLUP:   cfg_next[ctl_hit[1:0]].pullup_en = bus_req.wdata;
          `GPCFG_IDX_AFS_LOW:  cfg_next[ctl_hit[1:0]].afs_low  = bus_req.wdata;
          `GPCFG_IDX_AFS_HIGH: cfg_next[ctl_hit[1:0]].afs_high = bus_req.wdata;
          default: ;
        endcase
      end
      // Input data addresses take no write path at all.
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int p = 0; p < `GPCFG_NUM_PORTS; p++) begin
        cfg_reg[p] <= '{`GPCFG_CFG_RESET, `GPCFG_CFG_RESET,
                        `GPCFG_CFG_RESET, `GPCFG_CFG_RESET};
        idx_reg[p] <= `GPCFG_IDX_RESET;
      end
    end else begin
      for (int p = 0; p < `GPCFG_NUM_PORTS; p++) begin
        cfg_reg[p] <= cfg_next[p];
        idx_reg[p] <= idx_next[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling and stop-mode wake detection
  // ----------------------------------------------------------------
  // Pins are taken as already synchronous, so one sample stage and one
  // history stage suffice to see any edge. Stop mode must still be high
  // in the cycle in which the two stages differ: an edge that arrives in
  // the last cycle before stop mode ends is not reported.
  // Unbonded pins read low in both stages and can never wake the device.
  always_comb begin
    sample_next = visible;
    prev_next   = sample_reg;
    // Only wake-enabled pins that changed while stopped request recovery.
    recover_next = stop_mode &&
      (|(((sample_reg ^ prev_reg)) & {cfg_reg[3].wake_en, cfg_reg[2].wake_en,
                                      cfg_reg[1].wake_en, cfg_reg[0].wake_en}));
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sample_reg  <= 32'h00000000;
      prev_reg    <= 32'h00000000;
      recover_reg <= 1'b0;
    end else begin
      sample_reg  <= sample_next;
      prev_reg    <= prev_next;
      recover_reg <= recover_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is held until the next read, so software may fetch it late.
  // Index 02h and every unused index read back as zero: the function enable
  // bits live outside this block. Port D has no input register and reads 0.
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_req.rd) begin
      rdata_next = 8'h00;
      if (adr_hit[2])
        rdata_next = idx_reg[adr_hit[1:0]];
      else if (ctl_hit[2]) begin
        unique case (idx_reg[ctl_hit[1:0]])
          `GPCFG_IDX_WAKE_EN:  rdata_next = cfg_reg[ctl_hit[1:0]].wake_en;
          `GPCFG_IDX_PULLUP:   rdata_next = cfg_reg[ctl_hit[1:0]].pullup_en;
          `GPCFG_IDX_AFS_LOW:  rdata_next = cfg_reg[ctl_hit[1:0]].afs_low;
          `GPCFG_IDX_AFS_HIGH: rdata_next = cfg_reg[ctl_hit[1:0]].afs_high;
          default:             rdata_next = 8'h00;
        endcase
      end else if (in_hit[2] && in_hit[1:0] != 2'b11)
        rdata_next = sample_reg[8*in_hit[1:0] +: 8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // ----------------------------------------------------------------
  // Pin-side outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < `GPCFG_NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        // Pull-ups of unbonded pins stay off so that no current flows
        // into a pad that is not connected.
        pin_pullup_on[8*p+b] = cfg_reg[p].pullup_en[b] & PIN_PRESENT[8*p+b];
        // Select bits pass through the remap table, gated by the enable.
        pin_af_code[2*(8*p+b) +: 2] = pin_af_enable[8*p+b] ?
          ({cfg_reg[p].afs_high[b], cfg_reg[p].afs_low[b]} ^
           AF_CODE_MAP[2*(8*p+b) +: 2]) : 2'b00;
      end
    end
    // Codes of unbonded pins are left unmasked: no pad can carry them,
    // and ownership below already keeps such pins out of any function.
    pin_af_active = pin_af_enable & PIN_PRESENT;
    pin_normal_oe = ~pin_af_enable & ~pin_direction & PIN_PRESENT;
  end

  // Data outputs come straight from flip-flops so no decode glitch leaks out.
  assign bus_rdata    = rdata_reg;
  assign stop_recover = recover_reg;

endmodule // gpcfg_port_pins

// file: gpcfg_chk.sv
/*
  Port checker for the pin configuration block.
  Assumes a bind onto every instance of the block.
*/
`timescale 1ns/10ps
// ----------------------------------------
// Checker
// ----------------------------------------
module gpcfg_chk
  import gpcfg_pkg::*;
#(
  parameter logic [31:0] PIN_PRESENT = 32'hFFFFFFFF // Bonded pins.
) (
  input wire logic           ref_clk,       // Clock.
  input wire logic           resetn,        // Reset.
  input wire gpcfg_bus_req_t bus_req,       // Bus.
  input wire logic [7:0]     bus_rdata,     // Read data.
  input wire logic [31:0]    pin_level,     // Pins.
  input wire logic [31:0]    pin_af_enable, // Enables.
  input wire logic [31:0]    pin_direction, // Direction.
  input wire logic           stop_mode,     // Stop.
  input wire logic           stop_recover,  // Wake.
  input wire logic [31:0]    pin_pullup_on, // Pull-ups.
  input wire logic [31:0]    pin_af_active, // Owned.
  input wire logic [63:0]    pin_af_code,   // Codes.
  input wire logic [31:0]    pin_normal_oe  // Drive.
);
  logic [63:0] en2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_comb for (int i = 0; i < 32; i++) en2[2*i+:2] = {2{pin_af_enable[i]}};
  AST_WAKE_OFF: assert property (!$past(stop_mode) |-> !stop_recover)
    else $error("wake outside stop");
  AST_WAKE_CAUSE: assert property (stop_recover |-> $past(pin_level, 2) != $past(pin_level, 3))
    else $error("wake without edge");
  AST_PULL_WR: assert property ($changed(pin_pullup_on) |-> $past(bus_req.wr))
    else $error("pull-up moved alone");
  AST_PULL_ABSENT: assert property ((pin_pullup_on & ~PIN_PRESENT) == 32'h0)
    else $error("pull-up on absent pin");
  AST_AF_ACTIVE: assert property (pin_af_active == (pin_af_enable & PIN_PRESENT))
    else $error("bad owner");
  AST_CODE_OFF: assert property ((pin_af_code & ~en2) == 64'h0)
    else $error("code while off");
  AST_NORMAL_OE: assert property (pin_normal_oe == (~pin_af_enable & ~pin_direction & PIN_PRESENT))
    else $error("bad drive enable");
  AST_RD_HOLD: assert property (!$past(bus_req.rd) |-> $stable(bus_rdata))
    else $error("read data moved");
  AST_IN_READ: assert property ($past(bus_req.rd && bus_req.addr == 12'hFD2)
    |-> bus_rdata == ($past(pin_level[7:0], 2) & PIN_PRESENT[7:0]))
    else $error("bad input read");
  AST_RESET_CLEAR: assert property ($rose(resetn) |->
    pin_pullup_on == 32'h0 && bus_rdata == 8'h00 && !stop_recover)
    else $error("state not cleared by reset");
  cover property (stop_recover);
  cover property (bus_req.wr && bus_req.addr == 12'hFD1);
  cover property (bus_req.rd && bus_req.addr == 12'hFDA);
endmodule // gpcfg_chk

bind gpcfg_port_pins gpcfg_chk #(.PIN_PRESENT(PIN_PRESENT)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata), .pin_level(pin_level),
  .pin_af_enable(pin_af_enable), .pin_direction(pin_direction), .stop_mode(stop_mode),
  .stop_recover(stop_recover), .pin_pullup_on(pin_pullup_on),
  .pin_af_active(pin_af_active), .pin_af_code(pin_af_code), .pin_normal_oe(pin_normal_oe));

// file: gpcfg_pin_model.sv
/*
  Board-side pin model.
  Assumes pull-up requests come from the block.
*/
`timescale 1ns/10ps
module gpcfg_pin_model (
  input wire logic        ref_clk, // Clock.
  input wire logic [31:0] drv,     // Forced levels.
  input wire logic [31:0] drv_en,  // Pin forced.
  input wire logic [31:0] pull_on, // Pull-ups.
  output logic [31:0]     level    // Pin levels.
);
  logic [31:0] float_reg = 32'h55555555;
  always @(posedge ref_clk) float_reg <= ~float_reg;
  // Released pins sit high under a pull-up and wander otherwise.
  assign level = (drv & drv_en) | (~drv_en & (pull_on | float_reg));
endmodule // gpcfg_pin_model

// file: tb_gpcfg_port_pins.sv
/*
  Testbench for the pin configuration block.
  Assumes the checker bind and the pin model are compiled in.
*/
`timescale 1ns/10ps
module tb_gpcfg_port_pins;
  import gpcfg_pkg::*;
  localparam logic [31:0] PRES = 32'hFF7FFFFF;
  localparam logic [63:0] M = ~64'h0000C00000000000;
  logic ref_clk = 0, resetn = 0, stop_mode = 0, rec;
  gpcfg_bus_req_t bus_req = '0;
  logic [31:0] drv = 32'hC3A55A96, drv_en = '1, af_en = '0, dir = '1;
  logic [31:0] pull, level, act, oe, xp;
  logic [63:0] code, xc;
  logic [7:0]  rdata, lo, hi, pu;
  int          err_total = 0, comparisons = 0, n;
  always #50 ref_clk = ~ref_clk;
  gpcfg_port_pins #(.PIN_PRESENT(PRES)) uut (.ref_clk(ref_clk), .resetn(resetn),
    .bus_req(bus_req), .bus_rdata(rdata), .pin_level(level), .pin_af_enable(af_en),
    .pin_direction(dir), .stop_mode(stop_mode), .stop_recover(rec), .pin_pullup_on(pull),
    .pin_af_active(act), .pin_af_code(code), .pin_normal_oe(oe));
  gpcfg_pin_model u_pins (.ref_clk(ref_clk), .drv(drv), .drv_en(drv_en),
    .pull_on(pull), .level(level));
  function automatic logic [7:0] val(input logic [1:0] p, input logic [3:0] i);
    return 8'h3C ^ {p, i, p};
  endfunction
  task close_out;
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task go(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    bus_req = '{w, r, a, d};
    @(posedge ref_clk);
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    go(1'b0, 1'b1, a, 8'h00);
    cmp({56'h0, rdata}, {56'h0, e});
  endtask
  task wake_count(input logic [63:0] e);
    n = 0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      if (rec === 1'b1) n++;
    end
    cmp(64'(n), e);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 resetn = 1;
    for (int p = 0; p < 4; p++) for (int i = 5; i < 9; i++) begin
      go(1'b1, 1'b0, 12'hFD0 + 12'(p * 4), 8'(i));
      rd(12'hFD1 + 12'(p * 4), 8'h00);
      go(1'b1, 1'b0, 12'hFD1 + 12'(p * 4), val(2'(p), 4'(i)));
    end
    for (int p = 0; p < 4; p++) for (int i = 5; i < 9; i++) begin
      go(1'b1, 1'b0, 12'hFD0 + 12'(p * 4), 8'(i));
      rd(12'hFD1 + 12'(p * 4), val(2'(p), 4'(i)));
    end
    for (int p = 0; p < 4; p++) begin
      lo = val(2'(p), 4'h7);
      hi = val(2'(p), 4'h8);
      pu = val(2'(p), 4'h6);
      for (int b = 0; b < 8; b++) begin
        xp[8*p+b] = pu[b];
        xc[16*p+2*b+:2] = {hi[b], lo[b]};
      end
    end
    af_en = '1;
    go(1'b0, 1'b0, 12'h000, 8'h00);
    cmp({32'h0, pull}, {32'h0, xp & PRES});
    cmp(code & M, xc & M);
    af_en = 32'h0F0F00FF;
    dir = 32'h00FF0F0F;
    go(1'b0, 1'b0, 12'h000, 8'h00);
    cmp({32'h0, act}, {32'h0, 32'h0F0F00FF & PRES});
    cmp({32'h0, oe}, 64'h00000000F000F000);
    rd(12'hFD2, 8'h96);
    rd(12'hFD6, 8'h5A);
    rd(12'hFDA, 8'h25);
    rd(12'hFDE, 8'h00);
    go(1'b1, 1'b0, 12'hFD2, 8'h00);
    rd(12'hFD2, 8'h96);
    go(1'b1, 1'b0, 12'hFD4, 8'h06);
    go(1'b1, 1'b0, 12'hFD5, 8'hFF);
    drv_en = 32'hFFFF00FF;
    repeat (2) go(1'b0, 1'b0, 12'h000, 8'h00);
    rd(12'hFD6, 8'hFF);
    drv_en = '1;
    go(1'b1, 1'b0, 12'hFD0, 8'h05);
    go(1'b1, 1'b0, 12'hFD1, 8'h01);
    repeat (4) go(1'b0, 1'b0, 12'h000, 8'h00);
    stop_mode = 1;
    drv[1] = ~drv[1];
    wake_count(64'h0);
    drv[0] = ~drv[0];
    wake_count(64'h1);
    stop_mode = 0;
    resetn = 0;
    repeat (2) go(1'b0, 1'b0, 12'h000, 8'h00);
    resetn = 1;
    go(1'b1, 1'b0, 12'hFD4, 8'h06);
    rd(12'hFD5, 8'h00);
    cmp({32'h0, pull}, 64'h0);
    close_out();
  end
endmodule // tb_gpcfg_port_pins
